//--- logic/rstc_consts.svh
// Constants of the reset controller register block
`ifndef RSTC_CONSTS_SVH
`define RSTC_CONSTS_SVH

// ============================================================
// Register offsets
`define RSTC_OFS_COMMAND 8'h00
`define RSTC_OFS_STATUS 8'h04
`define RSTC_OFS_MODE 8'h08
`define RSTC_OFS_IRQ_STATUS 8'h0C
`define RSTC_OFS_IRQ_MASK 8'h10

// ============================================================
// Key field
`define RSTC_KEY_MSB 31
`define RSTC_KEY_LSB 24
`define RSTC_KEY_VALUE 8'hA5

// ============================================================
// Command bits
`define RSTC_CMD_CPU_BIT 0
`define RSTC_CMD_PERIPH_BIT 2
`define RSTC_CMD_PIN_BIT 3

// ============================================================
// Status fields
`define RSTC_ST_EDGE_BIT 0
`define RSTC_ST_CAUSE_LSB 8
`define RSTC_ST_LEVEL_BIT 16
`define RSTC_ST_BUSY_BIT 17

// ============================================================
// Mode fields
`define RSTC_MODE_EN_BIT 0
`define RSTC_MODE_IRQ_BIT 4
`define RSTC_MODE_LEN_LSB 8
`define RSTC_MODE_LEN_MSB 11

// ============================================================
// Interrupt status bits
`define RSTC_IRQ_EDGE_BIT 0
`define RSTC_IRQ_SWDONE_BIT 1

// ============================================================
// Reset values and timing
`define RSTC_MODE_RESET 32'h0000_0001
`define RSTC_STATUS_RESET 32'h0000_0000
`define RSTC_SW_SLOW_CYCLES 17'h0_0003
`define RSTC_USER_STARTUP_CYCLES 17'h0_0003
`define RSTC_WDOG_SLOW_CYCLES 17'h0_0003

`endif

//--- logic/rstc_pkg.sv
// Types of the reset controller register block
package rstc_pkg;

    typedef enum logic [2:0] {
        RSTC_CAUSE_GENERAL = 3'h0,
        RSTC_CAUSE_BACKUP = 3'h1,
        RSTC_CAUSE_WATCHDOG = 3'h2,
        RSTC_CAUSE_SOFTWARE = 3'h3,
        RSTC_CAUSE_USER = 3'h4
    } rstc_cause_type;

    typedef enum logic [2:0] {
        RSTC_ST_IDLE = 3'h0,
        RSTC_ST_SW = 3'h1,
        RSTC_ST_USER = 3'h2,
        RSTC_ST_USER_END = 3'h3,
        RSTC_ST_WDOG = 3'h4
    } rstc_state_type;

    // Slow clock cycles of the pin pulse: 2^(len+1)
    function automatic logic [16:0] rstc_pulse_cycles(input logic [3:0] len);
        logic [16:0] one;
        one = 17'h0_0001;
        rstc_pulse_cycles = one << ({1'b0, len} + 5'h01);
    endfunction : rstc_pulse_cycles

endpackage : rstc_pkg

//--- logic/rstc_slow_timer.sv
// Slow clock cycle down counter with busy and done
`timescale 1ns/1ps
module rstc_slow_timer #(
    parameter int CNT_W = 17
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [CNT_W-1:0] cycles,
    input wire logic slow_tick,
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic busy_nxt;
    logic done_nxt;
    logic last_tick;

    assign last_tick = busy && slow_tick && (cnt_r == CNT_W'(1));
    assign cnt_nxt = start ? cycles : (busy && slow_tick) ? cnt_r - CNT_W'(1) : cnt_r;
    assign busy_nxt = start ? 1'b1 : (last_tick ? 1'b0 : busy);
    assign done_nxt = last_tick && !start;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
            busy <= busy_nxt;
            done <= done_nxt;
        end
    end
endmodule : rstc_slow_timer

//--- logic/rstc_regs.sv
// Reset controller: keyed command, status, mode, pin pulse and irq
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "rstc_consts.svh"
module rstc_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic slow_tick,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    input wire logic backup_evt,
    input wire logic watchdog_evt,
    output logic cpu_reset,
    output logic periph_reset,
    output logic irq
);
    import rstc_pkg::*;

    // Mode reset word, split into its fields below
    localparam logic [31:0] MODE_RESET_WORD = `RSTC_MODE_RESET;

    // ============================================================
    // State
    rstc_state_type state_r;
    rstc_state_type state_nxt;
    rstc_cause_type cause_r;
    rstc_cause_type cause_nxt;
    logic pin_level_r;
    logic edge_flag_r;
    logic edge_flag_nxt;
    logic en_r;
    logic irq_en_r;
    logic [3:0] len_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_stat_nxt;
    logic [1:0] irq_mask_r;
    logic cmd_cpu_r;
    logic cmd_periph_r;
    logic cpu_reset_nxt;
    logic periph_reset_nxt;
    logic irq_nxt;
    logic [31:0] rdata_nxt;

    // ============================================================
    // Bus decode
    wire key_ok = (wdata[`RSTC_KEY_MSB:`RSTC_KEY_LSB] == `RSTC_KEY_VALUE);
    wire wr_cmd = wr_stb && (addr == `RSTC_OFS_COMMAND);
    wire wr_mode = wr_stb && (addr == `RSTC_OFS_MODE) && key_ok;
    wire wr_istat = wr_stb && (addr == `RSTC_OFS_IRQ_STATUS);
    wire wr_imask = wr_stb && (addr == `RSTC_OFS_IRQ_MASK);
    wire rd_status = rd_stb && (addr == `RSTC_OFS_STATUS);
    wire busy = (state_r == RSTC_ST_SW);
    wire idle_now = (state_r == RSTC_ST_IDLE);

    // Any of the three command bits set
    function automatic logic cmd_bits_set(input logic [31:0] word);
        cmd_bits_set = word[`RSTC_CMD_CPU_BIT] || word[`RSTC_CMD_PERIPH_BIT]
                       || word[`RSTC_CMD_PIN_BIT];
    endfunction : cmd_bits_set

    wire cmd_any = cmd_bits_set(wdata);
    // Keyed, idle and at least one command bit set
    wire sw_go = wr_cmd && key_ok && !busy && idle_now && cmd_any;
    wire sw_pin_go = sw_go && wdata[`RSTC_CMD_PIN_BIT];

    // ============================================================
    // Slow clock timers
    logic sw_start;
    logic [16:0] sw_cycles;
    logic sw_done;
    logic pin_echo_r;
    logic pin_start;
    logic pin_busy;
    logic pin_done;

    // Watchdog aborts a running software reset
    wire wdog_go = watchdog_evt && (state_r == RSTC_ST_IDLE || state_r == RSTC_ST_SW);
    wire pin_low = !pin_level_r;
    // Own pulse still echoes on the line for one cycle after pin_oe drops
    wire user_go = (state_r == RSTC_ST_IDLE) && en_r && pin_low && !pin_busy
                   && !pin_oe && !pin_echo_r && !sw_go && !wdog_go;
    wire user_rise = (state_r == RSTC_ST_USER) && !pin_low;

    assign sw_start = sw_go || wdog_go || user_rise;
    assign sw_cycles = wdog_go ? `RSTC_WDOG_SLOW_CYCLES
                     : user_rise ? `RSTC_USER_STARTUP_CYCLES
                     : `RSTC_SW_SLOW_CYCLES;
    assign pin_start = sw_pin_go || (wdog_go && !pin_busy);

    rstc_slow_timer #(
        .CNT_W(17)
    ) u_state_timer (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .start(sw_start),
        .cycles(sw_cycles),
        .slow_tick(slow_tick),
        .busy(),
        .done(sw_done)
    );

    rstc_slow_timer #(
        .CNT_W(17)
    ) u_pin_timer (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .start(pin_start),
        .cycles(rstc_pulse_cycles(len_r)),
        .slow_tick(slow_tick),
        .busy(pin_busy),
        .done(pin_done)
    );

    // ============================================================
    // Reset sequencer
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        case (state_r)
            RSTC_ST_IDLE: begin
                if (wdog_go) begin
                    state_nxt = RSTC_ST_WDOG;
                end else if (sw_go) begin
                    state_nxt = RSTC_ST_SW;
                end else if (user_go) begin
                    state_nxt = RSTC_ST_USER;
                end
            end
            RSTC_ST_SW: begin
                if (wdog_go) begin
                    state_nxt = RSTC_ST_WDOG;
                end else if (sw_done) begin
                    state_nxt = RSTC_ST_IDLE;
                    if (cmd_cpu_r) begin
                        cause_nxt = RSTC_CAUSE_SOFTWARE;
                    end
                end
            end
            RSTC_ST_USER: begin
                if (user_rise) begin
                    state_nxt = RSTC_ST_USER_END;
                end
            end
            RSTC_ST_USER_END: begin
                if (sw_done) begin
                    state_nxt = RSTC_ST_IDLE;
                    cause_nxt = RSTC_CAUSE_USER;
                end
            end
            RSTC_ST_WDOG: begin
                if (sw_done) begin
                    state_nxt = RSTC_ST_IDLE;
                    cause_nxt = RSTC_CAUSE_WATCHDOG;
                end
            end
            default: begin
                state_nxt = RSTC_ST_IDLE;
            end
        endcase
        if (backup_evt) begin
            cause_nxt = RSTC_CAUSE_BACKUP;
        end
    end

    // Reset outputs follow the state
    wire in_user = (state_nxt == RSTC_ST_USER) || (state_nxt == RSTC_ST_USER_END);
    wire in_wdog = (state_nxt == RSTC_ST_WDOG);
    wire in_sw = (state_nxt == RSTC_ST_SW);
    assign cpu_reset_nxt = in_user || in_wdog
                           || (in_sw && (sw_go ? wdata[`RSTC_CMD_CPU_BIT] : cmd_cpu_r));
    assign periph_reset_nxt = in_user || in_wdog
                              || (in_sw && (sw_go ? wdata[`RSTC_CMD_PERIPH_BIT]
                                                  : cmd_periph_r));

    // ============================================================
    // Flags and interrupt
    wire pin_fall = pin_level_r && !pin_in;
    // Set wins over the read clear
    assign edge_flag_nxt = pin_fall || (edge_flag_r && !rd_status);
    wire [1:0] irq_set = {sw_done && (state_r == RSTC_ST_SW), pin_fall};
    wire [1:0] irq_clr = wr_istat ? wdata[1:0] : 2'h0;
    assign irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);
    wire edge_irq = edge_flag_nxt && irq_en_r && !en_r;
    assign irq_nxt = edge_irq || |(irq_stat_nxt & irq_mask_r);

    // ============================================================
    // Read data
    wire [31:0] status_word = {14'h0000, busy, pin_level_r, 5'h00, cause_r,
                               7'h00, edge_flag_r};
    wire [31:0] mode_word = {20'h0_0000, len_r, 3'h0, irq_en_r, 3'h0, en_r};
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd_stb) begin
            case (addr)
                `RSTC_OFS_STATUS: begin
                    rdata_nxt = status_word;
                end
                `RSTC_OFS_MODE: begin
                    rdata_nxt = mode_word;
                end
                `RSTC_OFS_IRQ_STATUS: begin
                    rdata_nxt = {30'h0000_0000, irq_stat_r};
                end
                `RSTC_OFS_IRQ_MASK: begin
                    rdata_nxt = {30'h0000_0000, irq_mask_r};
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= RSTC_ST_IDLE;
            cause_r <= RSTC_CAUSE_GENERAL;
            // Released line idles high, so no false low after reset
            pin_level_r <= 1'b1;
            edge_flag_r <= 1'b0;
            cmd_cpu_r <= 1'b0;
            cmd_periph_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
            pin_level_r <= pin_in;
            edge_flag_r <= edge_flag_nxt;
            if (sw_go) begin
                cmd_cpu_r <= wdata[`RSTC_CMD_CPU_BIT];
                cmd_periph_r <= wdata[`RSTC_CMD_PERIPH_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_r <= MODE_RESET_WORD[`RSTC_MODE_EN_BIT];
            irq_en_r <= MODE_RESET_WORD[`RSTC_MODE_IRQ_BIT];
            len_r <= MODE_RESET_WORD[`RSTC_MODE_LEN_MSB:`RSTC_MODE_LEN_LSB];
            irq_mask_r <= 2'h0;
            irq_stat_r <= 2'h0;
        end else if (clk_en) begin
            if (wr_mode) begin
                en_r <= wdata[`RSTC_MODE_EN_BIT];
                irq_en_r <= wdata[`RSTC_MODE_IRQ_BIT];
                len_r <= wdata[`RSTC_MODE_LEN_MSB:`RSTC_MODE_LEN_LSB];
            end
            if (wr_imask) begin
                irq_mask_r <= wdata[1:0];
            end
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
            cpu_reset <= 1'b0;
            periph_reset <= 1'b0;
            irq <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else if (clk_en) begin
            rdata <= rdata_nxt;
            cpu_reset <= cpu_reset_nxt;
            periph_reset <= periph_reset_nxt;
            irq <= irq_nxt;
            pin_out <= 1'b0;
            pin_oe <= pin_start || (pin_busy && !pin_done);
        end
    end

    // ============================================================
    // Line echo guard
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_echo_r <= 1'b0;
        end else if (clk_en) begin
            pin_echo_r <= pin_oe;
        end
    end
endmodule : rstc_regs

//--- testbench/rstc_line_model.sv
// Model of the outside devices sharing the reset line
`timescale 1ns/1ps
module rstc_line_model (
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic hold_low,
    output logic pin_in
);
    // ============================================================
    // Wired line
    // Pull-up keeps the line high unless a party pulls it low
    assign pin_in = ((pin_oe && !pin_out) || hold_low) ? 1'b0 : 1'b1;
endmodule : rstc_line_model

//--- testbench/rstc_regs_monitor.sv
// Checker of the reset controller register block ports
`timescale 1ns/1ps
module rstc_regs_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic slow_tick,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic pin_in,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic backup_evt,
    input wire logic watchdog_evt,
    input wire logic cpu_reset,
    input wire logic periph_reset,
    input wire logic irq
);
    // ============================================================
    // Helpers
    logic [16:0] tick_cnt_r;
    logic [16:0] tick_cnt_nxt;
    logic key_cmd;
    logic st_rd;
    logic any_rst;
    // Slow ticks seen while the pin is driven
    assign tick_cnt_nxt = pin_oe ? tick_cnt_r + {16'h0000, slow_tick && clk_en} : 17'h00000;
    assign key_cmd = wr_stb && clk_en && addr == 8'h00 && wdata[31:24] == 8'hA5;
    assign st_rd = rd_stb && clk_en && addr == 8'h04;
    assign any_rst = cpu_reset || periph_reset || pin_oe;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_cnt_r <= 17'h00000;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end
    // ============================================================
    // Properties
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence idle_poll;
        st_rd ##1 rdata[17] == 1'b0 && !watchdog_evt;
    endsequence
    sequence fall_then_read;
        $fell(pin_in) && clk_en ##1 (clk_en && !rd_stb) [*2] ##1 st_rd;
    endsequence
    key_guard_a: assert property (
        wr_stb && clk_en && addr == 8'h00 && wdata[31:24] != 8'hA5 && !any_rst
        && pin_in && $past(pin_in) && !watchdog_evt |=> !any_rst)
        else $error("badly keyed command took effect");
    cpu_cmd_a: assert property (idle_poll ##0 (key_cmd && wdata[0]) |=> cpu_reset)
        else $error("processor reset missing after command");
    periph_cmd_a: assert property (idle_poll ##0 (key_cmd && wdata[2]) |=> periph_reset)
        else $error("peripheral reset missing after command");
    pin_cmd_a: assert property (idle_poll ##0 (key_cmd && wdata[3]) |=> pin_oe)
        else $error("pin not driven after command");
    pin_low_a: assert property (pin_oe |-> pin_out == 1'b0)
        else $error("driven pin level not low");
    edge_flag_a: assert property (fall_then_read |=> rdata[0])
        else $error("falling edge not flagged");
    pin_level_a: assert property (
        st_rd && $stable(pin_in) && $past(clk_en) && $past(rst_b) |=> rdata[16] == $past(pin_in))
        else $error("pin level bit wrong");
    pulse_len_a: assert property (
        $fell(pin_oe) |-> tick_cnt_r >= 17'h00002 && (tick_cnt_r & (tick_cnt_r - 17'h00001)) == 17'h00000)
        else $error("pin pulse length not a power of two");
endmodule : rstc_regs_monitor

bind rstc_regs rstc_regs_monitor u_mon (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .slow_tick(slow_tick), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .backup_evt(backup_evt), .watchdog_evt(watchdog_evt), .cpu_reset(cpu_reset),
    .periph_reset(periph_reset), .irq(irq));

//--- testbench/rstc_regs_tb.sv
// Self-checking bench of the reset controller register block
`timescale 1ns/1ps
module rstc_regs_tb;
    import rstc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic slow_tick = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic backup_evt = 1'b0;
    logic watchdog_evt = 1'b0;
    logic hold_low = 1'b0;
    logic [31:0] rdata;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic cpu_reset;
    logic periph_reset;
    logic irq;
    logic [31:0] v;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;

    always #2.5 clk = ~clk;

    rstc_regs DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .slow_tick(slow_tick),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .backup_evt(backup_evt),
        .watchdog_evt(watchdog_evt), .cpu_reset(cpu_reset), .periph_reset(periph_reset),
        .irq(irq));
    rstc_line_model u_line (.pin_out(pin_out), .pin_oe(pin_oe), .hold_low(hold_low),
        .pin_in(pin_in));

    // ============================================================
    // Slow tick every 16 cycles and run ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        slow_tick <= (cyc % 16 == 15);
        if (cyc == 6000) begin
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end

    // ============================================================
    // Bus and helper tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    // Status poll directly followed by a command write
    task automatic cmd(input logic [31:0] d);
        @(posedge clk);
        addr <= 8'h04;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr <= 8'h00;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask : cmd

    task automatic ticks(input int n);
        repeat (n) do @(posedge clk); while (slow_tick !== 1'b1);
    endtask : ticks

    // Ticks counted while the pin stays driven
    task automatic pulse_len;
        k = 0;
        while (pin_oe === 1'b1) begin
            k = k + ((slow_tick === 1'b1) ? 1 : 0);
            @(posedge clk);
            #1;
        end
    endtask : pulse_len

    task automatic settle;
        k = 0;
        repeat (2) @(posedge clk);
        #1;
        while ((cpu_reset | pin_oe) === 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k = k + 1;
        end
        chk("settle", (k < 300) ? 32'h1 : 32'h0, 32'h1);
        repeat (2) @(posedge clk);
    endtask : settle

    // ============================================================
    // Scenarios
    task automatic t_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h04);
        chk("status", v, 32'h00010000);
        rd(8'h08);
        chk("mode", v, 32'h00000001);
        rd(8'h14);
        chk("unmapped", v, 32'h00000000);
        $display("reset test done");
    endtask : t_reset

    task automatic t_key;
        cmd(32'h5A00000D);
        chk("bad key", {cpu_reset, periph_reset, pin_oe}, 3'h0);
        wr(8'h08, 32'h5A000F11);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h08);
        chk("mode", v, 32'h00000001);
        wr(8'h08, 32'hA5000F11);
        rd(8'h08);
        chk("mode", v & 32'h00FFFFFF, 32'h00000F11);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(8'h08, 32'hA5000000);
        clk_en <= 1'b1;
        rd(8'h08);
        chk("frozen", v & 32'h00FFFFFF, 32'h00000F11);
        $display("key test done");
    endtask : t_key

    task automatic t_sw;
        wr(8'h08, 32'hA5000000);
        ticks(1);
        cmd(32'hA5000005);
        chk("resets", {cpu_reset, periph_reset}, 2'h3);
        wr(8'h00, 32'hA5000008);
        rd(8'h04);
        chk("busy", v[17], 1'h1);
        chk("ignored", pin_oe, 1'h0);
        ticks(2);
        rd(8'h04);
        chk("busy", v[17], 1'h1);
        ticks(1);
        repeat (2) @(posedge clk);
        rd(8'h04);
        chk("busy", v[17], 1'h0);
        chk("cause", v[10:8], RSTC_CAUSE_SOFTWARE);
        chk("resets", {cpu_reset, periph_reset}, 2'h0);
        rd(8'h04);
        chk("cause", v[10:8], RSTC_CAUSE_SOFTWARE);
        $display("software reset test done");
    endtask : t_sw

    task automatic t_pin;
        wr(8'h08, 32'hA5000100);
        ticks(1);
        cmd(32'hA5000008);
        chk("drive", {pin_oe, pin_out, cpu_reset}, 3'h4);
        pulse_len();
        chk("len one", k, 32'h4);
        wr(8'h08, 32'hA5000000);
        ticks(1);
        cmd(32'hA5000008);
        pulse_len();
        chk("len zero", k, 32'h2);
        rd(8'h04);
        wr(8'h0C, 32'h3);
        $display("pin pulse test done");
    endtask : t_pin

    task automatic t_irq;
        wr(8'h08, 32'hA5000010);
        @(posedge clk);
        hold_low <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("irq", {irq, cpu_reset}, 2'h2);
        @(posedge clk);
        hold_low <= 1'b0;
        rd(8'h04);
        chk("flag", v[0], 1'h1);
        @(posedge clk);
        #1;
        chk("irq", irq, 1'h0);
        rd(8'h04);
        chk("flag", v[0], 1'h0);
        wr(8'h10, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk("mask", irq, 1'h1);
        wr(8'h0C, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk("clear", irq, 1'h0);
        wr(8'h10, 32'h0);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_user;
        wr(8'h08, 32'hA5000011);
        @(posedge clk);
        hold_low <= 1'b1;
        repeat (2) @(posedge clk);
        rd(8'h04);
        chk("flag", v[0], 1'h1);
        chk("user", {cpu_reset, periph_reset, irq}, 3'h6);
        @(posedge clk);
        hold_low <= 1'b0;
        settle();
        rd(8'h04);
        chk("cause", v[10:8], RSTC_CAUSE_USER);
        $display("pin reset test done");
    endtask : t_user

    task automatic t_events;
        cmd(32'hA5000001);
        @(posedge clk);
        watchdog_evt <= 1'b1;
        @(posedge clk);
        watchdog_evt <= 1'b0;
        settle();
        rd(8'h04);
        chk("cause", v[10:8], RSTC_CAUSE_WATCHDOG);
        chk("busy", v[17], 1'h0);
        @(posedge clk);
        backup_evt <= 1'b1;
        @(posedge clk);
        backup_evt <= 1'b0;
        rd(8'h04);
        chk("cause", v[10:8], RSTC_CAUSE_BACKUP);
        $display("event test done");
    endtask : t_events

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        t_reset();
        t_key();
        t_sw();
        t_pin();
        t_irq();
        t_user();
        t_events();
        t_reset();
        report_and_stop();
    end
endmodule : rstc_regs_tb
